// *** decr_defines.svh ***
// Purpose: constants for end-of-discharge detection and capacity relearn
// Assumes: all tunables arrive as static inputs from nonvolatile storage
// Notes:   charge state is coded with 128 meaning full
//
// What this block does
// RULE1: At or below the near-empty charge point (128 = full), voltage is favoured over current.
// RULE2: At or above the near-full charge point (128 = full), voltage is favoured over current.
// RULE3: At the first empty voltage, remaining capacity is loaded with the reserve and a relearn is evaluated.
// RULE4: An empty condition counts only after it held for the 8-bit filter count of periods (up to 255).
// RULE5: The reserve load also needs the configured number of periods of valid voltage readings.
// RULE6: A relearn needs a discharge from full to empty with no charging and current never over the ceiling.
// RULE7: A relearn may change learned full charge by at most the change cap, where 255 means 100 percent.
// RULE8: A relearn is skipped when the accumulated error is above the error ceiling.
// RULE9: For the first configured number of relearns the change cap is not applied.
// RULE10: At the final empty voltage, remaining capacity is forced to 0 when that option is enabled.
// RULE11: Learned full charge is all charge counted from full to empty plus the reserve, and is output.
// RULE12: Tunables are static inputs and every condition is evaluated once per measurement tick.
`ifndef DECR_DEFINES_SVH
`define DECR_DEFINES_SVH

`define DECR_CAP_W        16
`define DECR_CNT_W        8
`define DECR_FILT_N       3
`define DECR_FILT_EOD1    0
`define DECR_FILT_VALID   1
`define DECR_FILT_EOD2    2
`define DECR_FULL_RESET   16'h1036
`define DECR_LEARNS_RESET 8'h00
`define DECR_CNT_MAX      8'hff
`define DECR_CAP_SCALE    24'h0000ff
`define DECR_ZERO_CAP     16'h0000

`endif

// *** decr_pkg.sv ***
// Purpose: shared types for the relearn block
// Assumes: widths come from decr_defines.svh
// Notes:   none
`include "decr_defines.svh"

package decr_pkg;

  typedef logic [`DECR_CAP_W-1:0] decr_cap_t;
  typedef logic [`DECR_CNT_W-1:0] decr_cnt_t;

  typedef struct packed {
    decr_cnt_t count;
    logic      hit;
  } decr_filt_state_t;

endpackage : decr_pkg

// *** decr_filt_if.sv ***
// Purpose: carrier between the main block and one persistence filter
// Assumes: one clock, tick and ce from the same domain
// Notes:   none
`timescale 1ns/1ps

interface decr_filt_if;
  logic             ce;
  logic             tick;
  logic             cond;
  decr_pkg::decr_cnt_t limit;
  logic             hit;

  modport owner  (output ce, output tick, output cond, output limit,
                  input hit);
  modport filter (input ce, input tick, input cond, input limit,
                  output hit);
endinterface : decr_filt_if

// *** decr_persist.sv ***
// Purpose: counts consecutive ticks on which a condition holds
// Assumes: limit is static between ticks
// Notes:   hit is a registered level, limit 0 hits on the first tick
`timescale 1ns/1ps
`include "decr_defines.svh"

module decr_persist (
  input  wire logic CLK_SYS,
  input  wire logic RSTN,
  decr_filt_if.filter f
);

  decr_pkg::decr_filt_state_t st;
  decr_pkg::decr_filt_state_t next_st;
  decr_pkg::decr_cnt_t        inc;

  always_comb begin
    next_st = st;
    inc     = (st.count == `DECR_CNT_MAX) ? st.count
                                          : st.count + 8'h01;
    if (f.tick) begin                                 // [RULE12]
      if (f.cond) begin
        next_st.count = inc;
        next_st.hit   = (inc >= f.limit);             // [RULE4]
      end else begin
        next_st.count = 8'h00;
        next_st.hit   = 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      st <= '0;
    end else if (f.ce) begin
      st <= next_st;
    end
  end

  assign f.hit = st.hit;

endmodule : decr_persist

// *** decr_relearn.sv ***
// Purpose: end-of-discharge detection and learned full charge relearn
// Assumes: all inputs come from logic on CLK_SYS, no synchronisers
// Notes:   CURRENT is signed, positive while charging
`timescale 1ns/1ps
`include "decr_defines.svh"

module decr_relearn (
  input  wire logic        CLK_SYS,
  input  wire logic        RSTN,
  input  wire logic        CE,
  input  wire logic        TICK,
  // measurements
  input  wire logic [15:0] PACK_VOLTAGE,
  input  wire logic        PACK_VOLTAGE_VALID,
  input  wire logic signed [15:0] PACK_CURRENT,
  input  wire logic [7:0]  CHARGE_STATE,
  input  wire logic        FULLY_CHARGED,
  input  wire logic [15:0] COUNTED_DISCHARGE,
  input  wire logic [15:0] ACCUMULATED_ERROR,
  // tunables
  input  wire logic [7:0]  LOW_SOC_WEIGHTING_POINT,
  input  wire logic [7:0]  HIGH_SOC_WEIGHTING_POINT,
  input  wire logic [15:0] RESERVE_CAPACITY_VALUE,
  input  wire logic [7:0]  EMPTY_FILTER_COUNT,
  input  wire logic [7:0]  NEAR_EMPTY_VALID_COUNT,
  input  wire logic [15:0] LEARN_CURRENT_CEILING,
  input  wire logic [7:0]  LEARN_CHANGE_CAP,
  input  wire logic [15:0] LEARN_ERROR_CEILING,
  input  wire logic [7:0]  UNLIMITED_LEARN_CYCLES,
  input  wire logic [15:0] FIRST_EMPTY_VOLTAGE,
  input  wire logic [15:0] FINAL_EMPTY_VOLTAGE,
  input  wire logic        FINAL_EMPTY_ZERO_EN,
  // results
  output logic             VOLTAGE_WEIGHT_LOW,
  output logic             VOLTAGE_WEIGHT_HIGH,
  output logic             RESERVE_CAPACITY_LOAD,
  output logic             ZERO_CAPACITY_LOAD,
  output logic [15:0]      CAPACITY_LOAD_VALUE,
  output logic             LEARN_DONE,
  output logic             LEARN_SKIPPED,
  output logic             LEARN_QUALIFIED,
  output logic [15:0]      LEARNED_FULL_CHARGE,
  output logic [7:0]       LEARN_COUNT
);

  // ==========================================================
  // state
  // ==========================================================
  typedef struct packed {
    logic                weight_low;
    logic                weight_high;
    logic                qualified;
    logic                eod1_done;
    logic                eod2_done;
    logic                reserve_load;
    logic                zero_load;
    decr_pkg::decr_cap_t load_value;
    logic                learn_done;
    logic                learn_skipped;
    decr_pkg::decr_cap_t learned;
    decr_pkg::decr_cnt_t learns;
  } decr_state_t;

  decr_state_t st;
  decr_state_t next_st;

  // ==========================================================
  // helpers
  // ==========================================================
  function automatic logic at_or_below(input logic [15:0] v,
                                       input logic [15:0] th);
    at_or_below = (v <= th);
  endfunction : at_or_below

  function automatic logic [15:0] magnitude(input logic signed [15:0] c);
    magnitude = c[15] ? 16'(-c) : 16'(c);
  endfunction : magnitude

  // ==========================================================
  // persistence filters
  // ==========================================================
  logic [`DECR_FILT_N-1:0] filt_cond;
  logic [`DECR_FILT_N-1:0] filt_hit;
  decr_pkg::decr_cnt_t     filt_limit [`DECR_FILT_N];

  always_comb begin
    filt_cond[`DECR_FILT_EOD1]  = at_or_below(PACK_VOLTAGE,
                                              FIRST_EMPTY_VOLTAGE);
    filt_cond[`DECR_FILT_VALID] = PACK_VOLTAGE_VALID &&
                                  at_or_below(PACK_VOLTAGE,
                                              FIRST_EMPTY_VOLTAGE);
    filt_cond[`DECR_FILT_EOD2]  = at_or_below(PACK_VOLTAGE,
                                              FINAL_EMPTY_VOLTAGE);
    filt_limit[`DECR_FILT_EOD1]  = EMPTY_FILTER_COUNT;       // [RULE4]
    filt_limit[`DECR_FILT_VALID] = NEAR_EMPTY_VALID_COUNT;   // [RULE5]
    filt_limit[`DECR_FILT_EOD2]  = EMPTY_FILTER_COUNT;       // [RULE4]
  end

  genvar gi;
  generate
    for (gi = 0; gi < `DECR_FILT_N; gi = gi + 1) begin : g_filt
      decr_filt_if fi ();
      assign fi.ce    = CE;
      assign fi.tick  = TICK;
      assign fi.cond  = filt_cond[gi];
      assign fi.limit = filt_limit[gi];
      assign filt_hit[gi] = fi.hit;
      decr_persist u_persist (
        .CLK_SYS (CLK_SYS),
        .RSTN    (RSTN),
        .f       (fi)
      );
    end
  endgenerate

  // ==========================================================
  // relearn arithmetic
  // ==========================================================
  logic        eod1_event;
  logic        eod2_event;
  logic        charging;
  logic        over_ceiling;
  logic [16:0] candidate;
  logic [15:0] candidate_sat;
  logic [23:0] cap_product;
  logic [15:0] max_delta;
  logic [16:0] upper_bound;
  logic [15:0] lower_bound;
  logic        limit_active;
  logic [15:0] new_learned;

  always_comb begin
    eod1_event = filt_hit[`DECR_FILT_EOD1] &&                 // [RULE3]
                 filt_hit[`DECR_FILT_VALID] &&                // [RULE5]
                 !st.eod1_done;
    eod2_event = filt_hit[`DECR_FILT_EOD2] && !st.eod2_done;
    charging     = !PACK_CURRENT[15] && (PACK_CURRENT != 16'sh0000);
    over_ceiling = PACK_CURRENT[15] &&
                   (magnitude(PACK_CURRENT) > LEARN_CURRENT_CEILING);
    // full charge is what was counted plus what is left in reserve
    candidate     = {1'b0, COUNTED_DISCHARGE} +
                    {1'b0, RESERVE_CAPACITY_VALUE};          // [RULE11]
    candidate_sat = candidate[16] ? 16'hffff : candidate[15:0];
    cap_product   = st.learned * LEARN_CHANGE_CAP;
    max_delta     = 16'(cap_product / `DECR_CAP_SCALE);     // [RULE7]
    upper_bound   = {1'b0, st.learned} + {1'b0, max_delta};
    lower_bound   = (st.learned > max_delta) ?
                    st.learned - max_delta : 16'h0000;
    limit_active  = (st.learns >= UNLIMITED_LEARN_CYCLES);  // [RULE9]
    new_learned   = candidate_sat;
    if (limit_active) begin                                 // [RULE7]
      if ({1'b0, candidate_sat} > upper_bound) begin
        new_learned = upper_bound[16] ? 16'hffff : upper_bound[15:0];
      end else if (candidate_sat < lower_bound) begin
        new_learned = lower_bound;
      end
    end
  end

  // ==========================================================
  // next state
  // ==========================================================
  always_comb begin
    next_st               = st;
    next_st.reserve_load  = 1'b0;
    next_st.zero_load     = 1'b0;
    next_st.learn_done    = 1'b0;
    next_st.learn_skipped = 1'b0;
    if (TICK) begin                                         // [RULE12]
      next_st.weight_low  = (CHARGE_STATE <=
                             LOW_SOC_WEIGHTING_POINT);      // [RULE1]
      next_st.weight_high = (CHARGE_STATE >=
                             HIGH_SOC_WEIGHTING_POINT);     // [RULE2]

      // qualification of a full-to-empty discharge
      if (FULLY_CHARGED) begin
        next_st.qualified = 1'b1;
      end
      if (charging) begin
        next_st.qualified = FULLY_CHARGED;                  // [RULE6]
        next_st.eod1_done = 1'b0;
        next_st.eod2_done = 1'b0;
      end else if (over_ceiling) begin
        next_st.qualified = 1'b0;                           // [RULE6]
      end

      if (eod1_event && !charging) begin
        next_st.eod1_done    = 1'b1;
        next_st.reserve_load = 1'b1;                        // [RULE3]
        next_st.load_value   = RESERVE_CAPACITY_VALUE;
        next_st.qualified    = 1'b0;
        if (st.qualified && !over_ceiling) begin            // [RULE6]
          if (ACCUMULATED_ERROR > LEARN_ERROR_CEILING) begin
            next_st.learn_skipped = 1'b1;                   // [RULE8]
          end else begin
            next_st.learned    = new_learned;               // [RULE11]
            next_st.learn_done = 1'b1;
            if (st.learns != `DECR_CNT_MAX) begin
              next_st.learns = st.learns + 8'h01;           // [RULE9]
            end
          end
        end
      end

      if (eod2_event && !charging) begin
        next_st.eod2_done = 1'b1;
        if (FINAL_EMPTY_ZERO_EN) begin                      // [RULE10]
          next_st.zero_load    = 1'b1;
          next_st.reserve_load = 1'b0;
          next_st.load_value   = `DECR_ZERO_CAP;
        end
      end
    end
  end

  // ==========================================================
  // registers
  // ==========================================================
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      st         <= '0;
      st.learned <= `DECR_FULL_RESET;
      st.learns  <= `DECR_LEARNS_RESET;
    end else if (CE) begin
      st <= next_st;
    end
  end

  // ==========================================================
  // outputs
  // ==========================================================
  assign VOLTAGE_WEIGHT_LOW    = st.weight_low;
  assign VOLTAGE_WEIGHT_HIGH   = st.weight_high;
  assign RESERVE_CAPACITY_LOAD = st.reserve_load;
  assign ZERO_CAPACITY_LOAD    = st.zero_load;
  assign CAPACITY_LOAD_VALUE   = st.load_value;
  assign LEARN_DONE            = st.learn_done;
  assign LEARN_SKIPPED         = st.learn_skipped;
  assign LEARN_QUALIFIED       = st.qualified;
  assign LEARNED_FULL_CHARGE   = st.learned;
  assign LEARN_COUNT           = st.learns;

endmodule : decr_relearn

// *** decr_relearn_monitor.sv ***
// Purpose: concurrent checks on the relearn block ports
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to decr_relearn from the bench top file
`timescale 1ns/1ps

module decr_relearn_monitor (
  input wire logic               CLK_SYS,
  input wire logic               RSTN,
  input wire logic               CE,
  input wire logic               TICK,
  input wire logic signed [15:0] PACK_CURRENT,
  input wire logic [7:0]         CHARGE_STATE,
  input wire logic [15:0]        ACCUMULATED_ERROR,
  input wire logic [7:0]         LOW_SOC_WEIGHTING_POINT,
  input wire logic [7:0]         HIGH_SOC_WEIGHTING_POINT,
  input wire logic [15:0]        RESERVE_CAPACITY_VALUE,
  input wire logic [7:0]         LEARN_CHANGE_CAP,
  input wire logic [15:0]        LEARN_ERROR_CEILING,
  input wire logic [7:0]         UNLIMITED_LEARN_CYCLES,
  input wire logic               FINAL_EMPTY_ZERO_EN,
  input wire logic               VOLTAGE_WEIGHT_LOW,
  input wire logic               VOLTAGE_WEIGHT_HIGH,
  input wire logic               RESERVE_CAPACITY_LOAD,
  input wire logic               ZERO_CAPACITY_LOAD,
  input wire logic [15:0]        CAPACITY_LOAD_VALUE,
  input wire logic               LEARN_DONE,
  input wire logic               LEARN_SKIPPED,
  input wire logic               LEARN_QUALIFIED,
  input wire logic [15:0]        LEARNED_FULL_CHARGE,
  input wire logic [7:0]         LEARN_COUNT
);
  logic [15:0] prev_full;
  logic [31:0] step;

  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);

  // =====================================================
  // previous learned value and size of the last change
  always_ff @(posedge CLK_SYS) begin
    prev_full <= LEARNED_FULL_CHARGE;
  end
  assign step = (LEARNED_FULL_CHARGE > prev_full) ?
                {16'h0000, LEARNED_FULL_CHARGE - prev_full} :
                {16'h0000, prev_full - LEARNED_FULL_CHARGE};

  // =====================================================
  // assertions
  a_low_weight: assert property (CE && TICK |=>
    VOLTAGE_WEIGHT_LOW ==
    ($past(CHARGE_STATE) <= $past(LOW_SOC_WEIGHTING_POINT)))
    else $error("low weighting flag wrong");
  a_high_weight: assert property (CE && TICK |=>
    VOLTAGE_WEIGHT_HIGH ==
    ($past(CHARGE_STATE) >= $past(HIGH_SOC_WEIGHTING_POINT)))
    else $error("high weighting flag wrong");
  a_reserve_value: assert property (RESERVE_CAPACITY_LOAD |->
    CAPACITY_LOAD_VALUE == RESERVE_CAPACITY_VALUE) else $error("bad reserve");
  a_zero_value: assert property (ZERO_CAPACITY_LOAD |->
    FINAL_EMPTY_ZERO_EN && CAPACITY_LOAD_VALUE == 16'h0000)
    else $error("bad zero load");
  a_load_on_tick: assert property ($rose(RESERVE_CAPACITY_LOAD) ||
    $rose(ZERO_CAPACITY_LOAD) |-> $past(TICK) && $past(CE))
    else $error("load without tick");
  a_no_charge_load: assert property (CE && TICK &&
    PACK_CURRENT > 16'sh0000 |=> !RESERVE_CAPACITY_LOAD && !ZERO_CAPACITY_LOAD)
    else $error("load on charging tick");
  a_learn_needs_qual: assert property ($rose(LEARN_DONE) |->
    $past(LEARN_QUALIFIED)) else $error("learn without qualified discharge");
  a_skip_error: assert property ($rose(LEARN_SKIPPED) |->
    $past(ACCUMULATED_ERROR) > LEARN_ERROR_CEILING) else $error("bad skip");
  a_count_step: assert property ($rose(LEARN_DONE) |->
    LEARN_COUNT ==
    (($past(LEARN_COUNT) == 8'hff) ? 8'hff : $past(LEARN_COUNT) + 8'h01))
    else $error("learn count step wrong");
  a_change_cap: assert property ($rose(LEARN_DONE) &&
    $past(LEARN_COUNT) >= UNLIMITED_LEARN_CYCLES |-> step * 32'h000000ff <=
    {16'h0000, prev_full} * {24'h000000, LEARN_CHANGE_CAP})
    else $error("learned change over cap");
  a_full_hold: assert property (!$rose(LEARN_DONE) |->
    $stable(LEARNED_FULL_CHARGE)) else $error("learned value moved");

  c_learn: cover property ($rose(LEARN_DONE));
  c_skip: cover property ($rose(LEARN_SKIPPED));
  c_zero: cover property ($rose(ZERO_CAPACITY_LOAD));
  c_reserve: cover property ($rose(RESERVE_CAPACITY_LOAD));
endmodule : decr_relearn_monitor

// *** testbench.sv ***
// Purpose: self-checking bench for the relearn block
// Assumes: CE and reading validity are driven by the bench
// Notes:   weighting rows, four discharges, then hand-written cases
`timescale 1ns/1ps

module testbench;
  typedef struct { logic [7:0] cs; logic lo; logic hi; } decr_row_t;
  logic CLK_SYS, RSTN, CE, TICK, PACK_VOLTAGE_VALID, FULLY_CHARGED;
  logic FINAL_EMPTY_ZERO_EN, VOLTAGE_WEIGHT_LOW, VOLTAGE_WEIGHT_HIGH;
  logic RESERVE_CAPACITY_LOAD, ZERO_CAPACITY_LOAD, LEARN_DONE;
  logic LEARN_SKIPPED, LEARN_QUALIFIED;
  logic signed [15:0] PACK_CURRENT;
  logic [15:0] PACK_VOLTAGE, COUNTED_DISCHARGE, ACCUMULATED_ERROR;
  logic [15:0] RESERVE_CAPACITY_VALUE, LEARN_CURRENT_CEILING;
  logic [15:0] LEARN_ERROR_CEILING, FIRST_EMPTY_VOLTAGE, FINAL_EMPTY_VOLTAGE;
  logic [15:0] CAPACITY_LOAD_VALUE, LEARNED_FULL_CHARGE;
  logic [7:0]  CHARGE_STATE, LOW_SOC_WEIGHTING_POINT, EMPTY_FILTER_COUNT;
  logic [7:0]  HIGH_SOC_WEIGHTING_POINT, NEAR_EMPTY_VALID_COUNT;
  logic [7:0]  LEARN_CHANGE_CAP, UNLIMITED_LEARN_CYCLES, LEARN_COUNT;
  int          error_cnt, n_checks;
  decr_row_t   rows [5] = '{'{8'h06, 1'b1, 1'b0}, '{8'h07, 1'b0, 1'b0},
    '{8'h7a, 1'b0, 1'b1}, '{8'h79, 1'b0, 1'b0}, '{8'h80, 1'b0, 1'b1}};

  decr_relearn i_decr_relearn (.CLK_SYS, .RSTN, .CE, .TICK, .PACK_VOLTAGE,
    .PACK_VOLTAGE_VALID, .PACK_CURRENT, .CHARGE_STATE, .FULLY_CHARGED,
    .COUNTED_DISCHARGE, .ACCUMULATED_ERROR, .LOW_SOC_WEIGHTING_POINT,
    .HIGH_SOC_WEIGHTING_POINT, .RESERVE_CAPACITY_VALUE, .EMPTY_FILTER_COUNT,
    .NEAR_EMPTY_VALID_COUNT, .LEARN_CURRENT_CEILING, .LEARN_CHANGE_CAP,
    .LEARN_ERROR_CEILING, .UNLIMITED_LEARN_CYCLES, .FIRST_EMPTY_VOLTAGE,
    .FINAL_EMPTY_VOLTAGE, .FINAL_EMPTY_ZERO_EN, .VOLTAGE_WEIGHT_LOW,
    .VOLTAGE_WEIGHT_HIGH, .RESERVE_CAPACITY_LOAD, .ZERO_CAPACITY_LOAD,
    .CAPACITY_LOAD_VALUE, .LEARN_DONE, .LEARN_SKIPPED, .LEARN_QUALIFIED,
    .LEARNED_FULL_CHARGE, .LEARN_COUNT);

  always #2 CLK_SYS = ~CLK_SYS;

  // ===================================================
  // compare tasks and stimulus helpers
  task chk_bit(input string name, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %b seen %b", name, exp, got);
    end
  endtask : chk_bit

  task chk_val(input string name, input logic [15:0] exp,
               input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_val

  task tick();
    @(posedge CLK_SYS) TICK <= 1'b1;
    @(posedge CLK_SYS) TICK <= 1'b0;
    #1;
  endtask : tick

  // charging full tick, then discharge at the first empty voltage
  task discharge(input logic [15:0] cnt, input logic [15:0] err,
                 input logic signed [15:0] cur);
    FULLY_CHARGED <= 1'b1;
    PACK_CURRENT <= 16'sh01f4;
    PACK_VOLTAGE <= 16'h3000;
    tick();
    chk_bit("qualified", 1'b1, LEARN_QUALIFIED);
    FULLY_CHARGED <= 1'b0;
    PACK_CURRENT <= cur;
    PACK_VOLTAGE <= 16'h2000;
    COUNTED_DISCHARGE <= cnt;
    ACCUMULATED_ERROR <= err;
    tick();
    tick();
    chk_bit("early load", 1'b0, RESERVE_CAPACITY_LOAD);
    tick();
    chk_bit("reserve load", 1'b1, RESERVE_CAPACITY_LOAD);
    chk_val("load value", 16'h0064, CAPACITY_LOAD_VALUE);
  endtask : discharge

  task conclude();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude

  // ===================================================
  // main sequence
  initial begin
    {CLK_SYS, RSTN, TICK, FULLY_CHARGED, error_cnt, n_checks} = '0;
    {CE, PACK_VOLTAGE_VALID, FINAL_EMPTY_ZERO_EN} = 3'h7;
    {PACK_CURRENT, COUNTED_DISCHARGE, ACCUMULATED_ERROR} = '0;
    {PACK_VOLTAGE, CHARGE_STATE} = {16'h3000, 8'h40};
    {LOW_SOC_WEIGHTING_POINT, HIGH_SOC_WEIGHTING_POINT} = 16'h067a;
    {EMPTY_FILTER_COUNT, NEAR_EMPTY_VALID_COUNT} = 16'h0202;
    {LEARN_CHANGE_CAP, UNLIMITED_LEARN_CYCLES} = 16'hcd01;
    RESERVE_CAPACITY_VALUE = 16'h0064;
    LEARN_CURRENT_CEILING = 16'h0bb8;
    LEARN_ERROR_CEILING = 16'h00c8;
    FIRST_EMPTY_VOLTAGE = 16'h2328;
    FINAL_EMPTY_VOLTAGE = 16'h1f40;
    repeat (2) @(posedge CLK_SYS);
    #1;
    chk_val("learned reset", 16'h1036, LEARNED_FULL_CHARGE);
    chk_val("count reset", 16'h0000, {8'h00, LEARN_COUNT});
    RSTN <= 1'b1;
    foreach (rows[i]) begin
      CHARGE_STATE <= rows[i].cs;
      tick();
      chk_bit("weight low", rows[i].lo, VOLTAGE_WEIGHT_LOW);
      chk_bit("weight high", rows[i].hi, VOLTAGE_WEIGHT_HIGH);
    end
    discharge(16'h0320, 16'h0000, 16'shfc18);
    chk_bit("learn done", 1'b1, LEARN_DONE);
    chk_val("uncapped learn", 16'h0384, LEARNED_FULL_CHARGE);
    chk_val("count one", 16'h0001, {8'h00, LEARN_COUNT});
    tick();
    chk_bit("one load", 1'b0, RESERVE_CAPACITY_LOAD);
    discharge(16'h1f40, 16'h0000, 16'shfc18);
    chk_val("capped learn", 16'h0657, LEARNED_FULL_CHARGE);
    chk_val("count two", 16'h0002, {8'h00, LEARN_COUNT});
    discharge(16'h1f40, 16'h00c9, 16'shfc18);
    chk_bit("skipped", 1'b1, LEARN_SKIPPED);
    chk_val("kept learn", 16'h0657, LEARNED_FULL_CHARGE);
    discharge(16'h1f40, 16'h0000, 16'shf060);
    chk_bit("heavy done", 1'b0, LEARN_DONE);
    chk_bit("heavy skip", 1'b0, LEARN_SKIPPED);
    PACK_VOLTAGE <= 16'h1f40;
    repeat (3) tick();
    chk_bit("zero load", 1'b1, ZERO_CAPACITY_LOAD);
    chk_val("zero value", 16'h0000, CAPACITY_LOAD_VALUE);
    // charging clears the empty latches, then readings go invalid
    PACK_CURRENT <= 16'sh01f4;
    PACK_VOLTAGE <= 16'h3000;
    tick();
    PACK_CURRENT <= 16'shfc18;
    PACK_VOLTAGE <= 16'h2000;
    PACK_VOLTAGE_VALID <= 1'b0;
    repeat (3) tick();
    chk_bit("invalid load", 1'b0, RESERVE_CAPACITY_LOAD);
    PACK_VOLTAGE_VALID <= 1'b1;
    repeat (2) tick();
    // tick while frozen must not fire the pending load
    CE <= 1'b0;
    tick();
    chk_bit("frozen load", 1'b0, RESERVE_CAPACITY_LOAD);
    CE <= 1'b1;
    tick();
    chk_bit("late load", 1'b1, RESERVE_CAPACITY_LOAD);
    // final empty with the zero option off
    FINAL_EMPTY_ZERO_EN <= 1'b0;
    PACK_VOLTAGE <= 16'h1f40;
    repeat (3) tick();
    chk_bit("zero off", 1'b0, ZERO_CAPACITY_LOAD);
    chk_val("kept value", 16'h0064, CAPACITY_LOAD_VALUE);
    conclude();
  end

  initial begin
    repeat (2000) @(posedge CLK_SYS);
    error_cnt++;
    $display("BAD watchdog expected end seen timeout");
    conclude();
  end
endmodule : testbench

bind decr_relearn decr_relearn_monitor i_decr_relearn_monitor (.CLK_SYS,
  .RSTN, .CE, .TICK, .PACK_CURRENT, .CHARGE_STATE, .ACCUMULATED_ERROR,
  .LOW_SOC_WEIGHTING_POINT, .HIGH_SOC_WEIGHTING_POINT,
  .RESERVE_CAPACITY_VALUE, .LEARN_CHANGE_CAP, .LEARN_ERROR_CEILING,
  .UNLIMITED_LEARN_CYCLES, .FINAL_EMPTY_ZERO_EN, .VOLTAGE_WEIGHT_LOW,
  .VOLTAGE_WEIGHT_HIGH, .RESERVE_CAPACITY_LOAD, .ZERO_CAPACITY_LOAD,
  .CAPACITY_LOAD_VALUE, .LEARN_DONE, .LEARN_SKIPPED, .LEARN_QUALIFIED,
  .LEARNED_FULL_CHARGE, .LEARN_COUNT);
